// ===== mac_side_data_end.sv
/*
  MAC end of the data interface: sends nibbles, collects received nibbles.
  Assumes mode_in matches the transceiver's strapped mode; drives the RMII
  reference as a 50 MHz level toggling every system clock.
*/
`timescale 1ns/1ps
module mac_side_data_end (
  input  wire logic                clock_in,
  input  wire logic                rst_n_in,
  input  wire phy_mac_pkg::mode_t  mode_in,
  input  wire logic                tx_valid_in,
  input  wire logic [3:0]          tx_data_in,
  output logic                     tx_ready_out,
  output logic                     rx_valid_out,
  output logic [3:0]               rx_data_out,
  output logic                     rx_error_out,
  output logic                     carrier_out,
  output logic                     collision_out,
  phy_mac_link.mac                 link
);
  import phy_mac_pkg::*;

  logic       ref_clk;
  logic       tx_clk_q;
  logic       rx_clk_q;
  logic       tx_beat;
  logic       rx_beat;
  logic       tx_en;
  logic [3:0] txd;
  logic [3:0] tx_cur;
  logic [1:0] tx_idx;
  logic       rx_framed;
  logic [3:0] rx_sh;
  logic [1:0] rx_idx;
  logic       rx_err_acc;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ref_clk  <= 1'b0;
      tx_clk_q <= 1'b0;
      rx_clk_q <= 1'b0;
    end else begin
      ref_clk  <= ~ref_clk;
      tx_clk_q <= link.tx_clk;
      rx_clk_q <= link.rx_clk;
    end
  end

  assign link.ref_clk = ref_clk;

  // RMII timed from reference
  // Acting while ref is low changes data on the edge where ref rises, a full cycle ahead of the sample
  // drive on device tx clock
  assign tx_beat = (mode_in == MODE_RMII) ? !ref_clk : (link.tx_clk && !tx_clk_q);
  assign rx_beat = (mode_in == MODE_RMII) ? !ref_clk : (link.rx_clk && !rx_clk_q);

  assign tx_ready_out = tx_beat && (tx_idx == 2'h0);

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_en  <= 1'b0;
      txd    <= 4'h0;
      tx_cur <= 4'h0;
      tx_idx <= 2'h0;
    end else if (tx_beat) begin
      if (tx_idx != 2'h0) begin
        tx_cur <= lane_shift(mode_in, tx_cur);
        txd    <= lane_slice(mode_in, lane_shift(mode_in, tx_cur));
        tx_idx <= tx_idx - 1'b1;
      end else if (tx_valid_in) begin
        tx_en  <= 1'b1;
        tx_cur <= tx_data_in;
        txd    <= lane_slice(mode_in, tx_data_in);
        tx_idx <= lane_last(mode_in);
      end else begin
        tx_en  <= 1'b0;
        txd    <= 4'h0;
      end
    end
  end

  assign link.tx_en = tx_en;
  assign link.txd   = txd;

  // Serial data is framed by carrier, the others by data valid
  assign rx_framed = (mode_in == MODE_SERIAL) ? link.crs : link.rx_dv;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_sh        <= 4'h0;
      rx_idx       <= 2'h0;
      rx_err_acc   <= 1'b0;
      rx_valid_out <= 1'b0;
      rx_data_out  <= 4'h0;
      rx_error_out <= 1'b0;
    end else begin
      rx_valid_out <= 1'b0;
      if (rx_beat) begin
        if (!rx_framed) begin
          rx_idx     <= 2'h0;
          rx_err_acc <= 1'b0;
        end else if (rx_idx == lane_last(mode_in)) begin
          rx_idx       <= 2'h0;
          rx_err_acc   <= 1'b0;
          rx_valid_out <= 1'b1;
          rx_data_out  <= lane_merge(mode_in, rx_sh, link.rxd);
          rx_error_out <= rx_err_acc || link.rx_er;
        end else begin
          rx_sh      <= lane_merge(mode_in, rx_sh, link.rxd);
          rx_idx     <= rx_idx + 1'b1;
          rx_err_acc <= rx_err_acc || link.rx_er;
        end
      end
    end
  end

  // RMII collision from crs_dv and enable
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      carrier_out   <= 1'b0;
      collision_out <= 1'b0;
    end else begin
      carrier_out   <= link.crs;
      collision_out <= (mode_in == MODE_RMII) ? (tx_en && link.crs) : link.col;
    end
  end
endmodule

// ===== phy_mac_link.sv
/*
  Pin-level carrier between the transceiver end and the MAC end.
  All signals are single-driver and sampled on the common system clock.
*/
`timescale 1ns/1ps
interface phy_mac_link;
  logic       tx_clk;
  logic       rx_clk;
  logic       ref_clk;
  logic       tx_en;
  logic [3:0] txd;
  logic       rx_dv;
  logic       rx_er;
  logic [3:0] rxd;
  logic       crs;
  logic       col;

  modport phy (
    input  ref_clk, tx_en, txd,
    output tx_clk, rx_clk, rx_dv, rx_er, rxd, crs, col
  );

  modport mac (
    input  tx_clk, rx_clk, rx_dv, rx_er, rxd, crs, col,
    output ref_clk, tx_en, txd
  );
endinterface

// ===== phy_mac_link_properties.sv
/*
  Assertions on the pins between the transceiver end and the MAC end.
  Assumes straps, speed and duplex change only while reset is low.
*/
`timescale 1ns/1ps
module phy_mac_link_properties (
  input wire logic               clock_in,
  input wire logic               rst_n_in,
  input wire phy_mac_pkg::mode_t mode_out,
  input wire logic               speed_100_in,
  input wire logic               full_duplex_in,
  input wire logic               heartbeat_en_in,
  input wire logic               line_carrier_in,
  input wire logic               tx_clk,
  input wire logic               rx_clk,
  input wire logic               tx_en,
  input wire logic               rx_dv,
  input wire logic               rx_er,
  input wire logic [3:0]         rxd,
  input wire logic               crs,
  input wire logic               col
);
  import phy_mac_pkg::*;
  logic [7:0] high_run;

  default clocking dc @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  // Slow half period is too long for a plain repetition
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      high_run <= 8'h00;
    end else begin
      high_run <= tx_clk ? high_run + 8'h01 : 8'h00;
    end
  end

  AST_RMII_CLK_IDLE: assert property (mode_out == MODE_RMII |-> !tx_clk && !rx_clk)
    else $error("link clock runs in rmii mode");
  AST_RX_FAST: assert property (mode_out == MODE_MII && speed_100_in && $rose(rx_clk)
    |-> rx_clk [*2] ##1 !rx_clk) else $error("fast receive clock high phase wrong");
  AST_CARRIER: assert property (line_carrier_in |=> crs)
    else $error("carrier sense low while medium busy");
  AST_MII_FAST: assert property (mode_out == MODE_MII && speed_100_in && $rose(tx_clk)
    |-> tx_clk [*2] ##1 !tx_clk) else $error("fast clock high phase wrong");
  AST_MII_SLOW: assert property (mode_out == MODE_MII && !speed_100_in && $fell(tx_clk)
    |-> high_run == 8'h14) else $error("slow clock high phase wrong");
  AST_SERIAL_CLK: assert property (mode_out == MODE_SERIAL && $rose(rx_clk)
    |-> rx_clk [*5] ##1 !rx_clk) else $error("serial clock high phase wrong");
  AST_FD_NO_COL: assert property (full_duplex_in && $past(full_duplex_in) |-> !col)
    else $error("collision in full duplex");
  AST_COLLIDE: assert property (!full_duplex_in && mode_out != MODE_RMII && tx_en
    && line_carrier_in |-> ##[1:2] col) else $error("collision missing");
  AST_HEARTBEAT: assert property (!full_duplex_in && heartbeat_en_in && !speed_100_in
    && mode_out != MODE_RMII && $fell(tx_en) |-> ##[1:3] col [*8])
    else $error("heartbeat missing");
  AST_ERR_QUAL: assert property (rx_er |-> rx_dv && speed_100_in
    && mode_out != MODE_SERIAL) else $error("receive error out of place");
  AST_ERR_CORRUPT: assert property (mode_out == MODE_MII && rx_er
    |-> rxd == CORRUPT_NIBBLE) else $error("errored nibble not corrupted");
  AST_RMII_RXD: assert property (mode_out == MODE_RMII |-> rxd[3:2] == 2'h0)
    else $error("rmii upper receive bits driven");
  AST_SERIAL_RXD: assert property (mode_out == MODE_SERIAL
    |-> rxd[3:1] == 3'h0 && !rx_er) else $error("serial unused pins driven");
  AST_DV_CRS: assert property (rx_dv |=> crs)
    else $error("carrier low during valid data");
endmodule

// ===== phy_mac_pkg.sv
/*
  Shared constants, mode type and lane helpers for the MAC data link.
  Assumes one 100 MHz system clock. Every link clock is derived from it.
*/
package phy_mac_pkg;

  typedef enum logic [1:0] {
    MODE_MII    = 2'b00,
    MODE_RMII   = 2'b01,
    MODE_SERIAL = 2'b10
  } mode_t;

  localparam int CLK_PERIOD_NS   = 10;
  // Link clock periods
  localparam int PERIOD_25M_NS   = 40;
  localparam int PERIOD_2M5_NS   = 400;
  localparam int PERIOD_10M_NS   = 100;
  localparam int HALF_25M_CYC    = PERIOD_25M_NS / (2 * CLK_PERIOD_NS);
  localparam int HALF_2M5_CYC    = PERIOD_2M5_NS / (2 * CLK_PERIOD_NS);
  localparam int HALF_10M_CYC    = PERIOD_10M_NS / (2 * CLK_PERIOD_NS);
  localparam int DIV_W           = 5;

  // Heartbeat pulse; approximate, so rounded down
  localparam int HEARTBEAT_NS    = 1000;
  localparam int HEARTBEAT_CYC   = HEARTBEAT_NS / CLK_PERIOD_NS;
  localparam int HB_W            = 7;

  localparam int NIBBLE_W        = 4;
  localparam int TX_FIFO_DEPTH   = 16;
  localparam logic [3:0] CORRUPT_NIBBLE = 4'h5;
  localparam mode_t      MODE_RESET     = MODE_MII;

  // Beats per nibble minus one
  function automatic logic [1:0] lane_last(input mode_t m);
    case (m)
      MODE_RMII:   lane_last = 2'h1;
      MODE_SERIAL: lane_last = 2'h3;
      default:     lane_last = 2'h0;
    endcase
  endfunction

  // Bits of a nibble that appear on the data pins
  function automatic logic [3:0] lane_slice(input mode_t m, input logic [3:0] n);
    case (m)
      MODE_RMII:   lane_slice = {2'h0, n[1:0]};
      MODE_SERIAL: lane_slice = {3'h0, n[0]};
      default:     lane_slice = n;
    endcase
  endfunction

  // Drop the bits already sent
  function automatic logic [3:0] lane_shift(input mode_t m, input logic [3:0] n);
    case (m)
      MODE_RMII:   lane_shift = {2'h0, n[3:2]};
      MODE_SERIAL: lane_shift = {1'h0, n[3:1]};
      default:     lane_shift = 4'h0;
    endcase
  endfunction

  // Collect pin bits, low bits first, into a nibble
  function automatic logic [3:0] lane_merge(input mode_t m, input logic [3:0] sh,
                                            input logic [3:0] d);
    case (m)
      MODE_RMII:   lane_merge = {d[1:0], sh[3:2]};
      MODE_SERIAL: lane_merge = {d[0], sh[3:1]};
      default:     lane_merge = d;
    endcase
  endfunction

endpackage

// ===== phy_mac_side_data_interface.sv
/*
  Transceiver end of the MAC data interface: MII, RMII and serial 10 Mb/s.
  Assumes the MAC end drives the 50 MHz reference as a level toggling on the
  system clock, and a line side that supplies receive nibbles and drains the
  transmit FIFO. Recovered receive clock is modelled by the local divider.
*/
// Contract
// - MII tx clock 25 or 2.5 MHz
// - RMII clocks unused, reference times both
// - Serial mode tx clock 10 MHz
// - MAC drives serial transmit on tx clock
// - MAC holds enable high during valid data
// - Sample tx data on mode's clock
// - MII rx clock 25 or 2.5 MHz
// - Serial mode rx clock 10 MHz
// - MII rx nibble valid with data valid
// - Data valid strap defaults MII; serial unused
// - RMII data valid independent of carrier
// - MII 100M receive error on bad symbol
// - RMII 100M receive error while valid
// - Corrupt data on error; serial error unused
// - RMII two rx bits on reference
// - Serial rx bit framed by carrier
// - Carrier sense high while medium busy
// - RMII carrier and valid merged on crs
// - Half duplex collision on simultaneous activity
// - 10M heartbeat collision about 1 us
// - Full duplex collision held low
// - RMII MAC derives collision itself
`timescale 1ns/1ps
module phy_mac_side_data_interface (
  input  wire logic            clock_in,
  input  wire logic            rst_n_in,
  input  wire logic            strap_rmii_in,
  input  wire logic            strap_serial_in,
  input  wire logic            speed_100_in,
  input  wire logic            full_duplex_in,
  input  wire logic            heartbeat_en_in,
  input  wire logic            line_carrier_in,
  input  wire logic            line_rx_valid_in,
  input  wire logic [3:0]      line_rx_data_in,
  input  wire logic            line_rx_error_in,
  output logic                 line_rx_ready_out,
  output logic                 line_tx_valid_out,
  output logic [3:0]           line_tx_data_out,
  input  wire logic            line_tx_ready_in,
  output logic                 line_tx_active_out,
  output logic                 tx_overflow_out,
  output phy_mac_pkg::mode_t   mode_out,
  phy_mac_link.phy             link
);
  import phy_mac_pkg::*;

  mode_t            mode;
  logic             strap_taken;
  logic             is_rmii;
  logic             slow_10m;
  logic [DIV_W-1:0] half_cyc;
  logic [DIV_W-1:0] div_cnt;
  logic             link_clk;
  logic             clk_rise;
  logic             ref_q;
  logic             beat;
  logic [3:0]       tx_sh;
  logic [1:0]       tx_idx;
  logic [3:0]       next_tx_sh;
  logic             tx_push;
  logic             fifo_ready;
  logic             tx_en_q;
  logic [3:0]       rx_cur;
  logic [1:0]       rx_idx;
  logic [3:0]       rx_nib;
  logic             rx_dv;
  logic             rx_err;
  logic [3:0]       rxd;
  logic             crs;
  logic             col;
  logic [HB_W-1:0]  hb_cnt;

  // strap capture
  // Straps are caught one edge after release, never inside the reset branch
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode        <= MODE_RESET;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      if (strap_serial_in) begin
        mode <= MODE_SERIAL;
      end else if (strap_rmii_in) begin
        mode <= MODE_RMII;
      end else begin
        mode <= MODE_MII;
      end
    end
  end

  assign is_rmii  = mode == MODE_RMII;
  assign slow_10m = (mode == MODE_SERIAL) || !speed_100_in;
  assign mode_out = mode;

  always_comb begin
    if (mode == MODE_SERIAL) begin
      half_cyc = DIV_W'(HALF_10M_CYC);
    end else if (speed_100_in) begin
      half_cyc = DIV_W'(HALF_25M_CYC);
    end else begin
      half_cyc = DIV_W'(HALF_2M5_CYC);
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt  <= '0;
      link_clk <= 1'b0;
    end else if (is_rmii || !strap_taken) begin
      div_cnt  <= '0;
      link_clk <= 1'b0;
    end else if (div_cnt >= half_cyc - 1'b1) begin
      div_cnt  <= '0;
      link_clk <= ~link_clk;
    end else begin
      div_cnt  <= div_cnt + 1'b1;
    end
  end

  // MII and serial rx clock
  // No line recovery here, so rx and tx clocks are one waveform
  assign link.tx_clk = link_clk;
  assign link.rx_clk = link_clk;

  assign clk_rise = !is_rmii && strap_taken && !link_clk && (div_cnt >= half_cyc - 1'b1);

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= link.ref_clk;
    end
  end

  assign beat = is_rmii ? (link.ref_clk && !ref_q) : clk_rise;

  assign next_tx_sh = lane_merge(mode, tx_sh, link.txd);
  assign tx_push    = beat && link.tx_en && (tx_idx == lane_last(mode));

  // tx pin bits sampled on mode's clock, reference rise in RMII
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_sh  <= 4'h0;
      tx_idx <= 2'h0;
    end else if (beat) begin
      if (!link.tx_en) begin
        tx_idx <= 2'h0;
      end else begin
        tx_sh  <= next_tx_sh;
        tx_idx <= (tx_idx == lane_last(mode)) ? 2'h0 : tx_idx + 1'b1;
      end
    end
  end

  sync_fifo #(
    .WIDTH (NIBBLE_W),
    .DEPTH (TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (tx_push),
    .in_data_in    (next_tx_sh),
    .in_ready_out  (fifo_ready),
    .out_valid_out (line_tx_valid_out),
    .out_data_out  (line_tx_data_out),
    .out_ready_in  (line_tx_ready_in)
  );

  // The MAC cannot be stalled, so a full FIFO drops the nibble and says so
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_overflow_out <= 1'b0;
      tx_en_q         <= 1'b0;
    end else begin
      tx_overflow_out <= tx_push && !fifo_ready;
      tx_en_q         <= link.tx_en;
    end
  end

  assign line_tx_active_out = tx_en_q;

  // Receive side asks for a nibble at each nibble boundary
  assign line_rx_ready_out = beat && (rx_idx == 2'h0);
  assign rx_nib = line_rx_error_in ? CORRUPT_NIBBLE : line_rx_data_in;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_cur <= 4'h0;
      rx_idx <= 2'h0;
      rx_dv  <= 1'b0;
      rx_err <= 1'b0;
      rxd    <= 4'h0;
    end else if (beat) begin
      if (rx_idx != 2'h0) begin
        rx_cur <= lane_shift(mode, rx_cur);
        rxd    <= lane_slice(mode, lane_shift(mode, rx_cur));
        rx_idx <= rx_idx - 1'b1;
      end else if (line_rx_valid_in) begin
        rx_cur <= rx_nib;
        rxd    <= lane_slice(mode, rx_nib);
        rx_idx <= lane_last(mode);
        rx_dv  <= 1'b1;
        rx_err <= line_rx_error_in && speed_100_in && (mode != MODE_SERIAL);
      end else begin
        rxd    <= 4'h0;
        rx_dv  <= 1'b0;
        rx_err <= 1'b0;
      end
    end
  end

  assign link.rx_dv = (mode == MODE_SERIAL) ? 1'b0 : rx_dv;
  assign link.rx_er = (mode == MODE_SERIAL) ? 1'b0 : (rx_err && rx_dv);
  assign link.rxd   = rxd;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      crs <= 1'b0;
    end else begin
      crs <= line_carrier_in || rx_dv;
    end
  end

  assign link.crs = crs;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hb_cnt <= '0;
    end else if (tx_en_q && !link.tx_en && slow_10m && !full_duplex_in
                 && heartbeat_en_in && !is_rmii) begin
      hb_cnt <= HB_W'(HEARTBEAT_CYC);
    end else if (hb_cnt != '0) begin
      hb_cnt <= hb_cnt - 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      col <= 1'b0;
    end else if (full_duplex_in || is_rmii) begin
      col <= 1'b0;
    end else begin
      col <= (link.tx_en && line_carrier_in) || (hb_cnt != '0);
    end
  end

  assign link.col = col;
endmodule

// ===== sync_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock; DEPTH is a power of two.
*/
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 16
) (
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready_out  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid_out = wr_ptr != rd_ptr;
  assign out_data_out  = mem[rd_ptr[AW-1:0]];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// ===== tb.sv
/*
  Self-checking bench: both link ends joined by the interface, line side
  driven here. Assumes the MAC is always handed whole nibbles.
*/
`timescale 1ns/1ps
module tb;
  import phy_mac_pkg::*;
  logic        clock_in, rst_n_in, strap_rmii_in, strap_serial_in, speed_100_in;
  logic        full_duplex_in, heartbeat_en_in, line_carrier_in, line_rx_valid_in;
  logic        line_rx_error_in, line_rx_ready_out, line_tx_valid_out, line_tx_ready_in;
  logic        line_tx_active_out, tx_overflow_out, tx_valid_in, tx_ready_out;
  logic        rx_valid_out, rx_error_out, carrier_out, collision_out, stall, prev_en;
  logic        prev_crs, prev_col;
  logic [3:0]  line_rx_data_in, line_tx_data_out, tx_data_in, rx_data_out;
  logic [31:0] rnd;
  mode_t       mode_out, mode_in;
  logic [3:0]  exp_tx[$];
  logic [4:0]  exp_rx[$];
  int          fail_count, comparisons, cycles, ovf_count;

  phy_mac_link u_phy_mac_link ();
  phy_mac_side_data_interface u_phy_mac_side_data_interface (
    .clock_in, .rst_n_in, .strap_rmii_in, .strap_serial_in, .speed_100_in,
    .full_duplex_in, .heartbeat_en_in, .line_carrier_in, .line_rx_valid_in,
    .line_rx_data_in, .line_rx_error_in, .line_rx_ready_out, .line_tx_valid_out,
    .line_tx_data_out, .line_tx_ready_in, .line_tx_active_out, .tx_overflow_out,
    .mode_out, .link(u_phy_mac_link));
  mac_side_data_end u_mac_side_data_end (
    .clock_in, .rst_n_in, .mode_in, .tx_valid_in, .tx_data_in, .tx_ready_out,
    .rx_valid_out, .rx_data_out, .rx_error_out, .carrier_out, .collision_out,
    .link(u_phy_mac_link));
  phy_mac_link_properties chk (
    .clock_in, .rst_n_in, .mode_out, .speed_100_in, .full_duplex_in, .heartbeat_en_in,
    .line_carrier_in, .tx_clk(u_phy_mac_link.tx_clk), .rx_clk(u_phy_mac_link.rx_clk),
    .tx_en(u_phy_mac_link.tx_en), .rx_dv(u_phy_mac_link.rx_dv),
    .rx_er(u_phy_mac_link.rx_er), .rxd(u_phy_mac_link.rxd), .crs(u_phy_mac_link.crs),
    .col(u_phy_mac_link.col));

  always #5 clock_in = ~clock_in;

  function automatic logic [31:0] draw();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Drain side stalls at random; the MAC side cannot be held off
  always @(posedge clock_in) begin
    line_tx_ready_in <= !stall && ((draw() & 32'h1) != 32'h0);
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  // Settled outputs are compared at the falling edge
  always @(negedge clock_in) begin
    logic [4:0] e;
    if (rst_n_in) begin
      check({7'h0, line_tx_active_out}, {7'h0, prev_en});
      if (line_tx_valid_out && line_tx_ready_in) begin
        if (exp_tx.size() == 0) check(8'h1, 8'h0);
        else check({4'h0, line_tx_data_out}, {4'h0, exp_tx.pop_front()});
      end
      if (rx_valid_out && exp_rx.size() == 0) check(8'h1, 8'h0);
      if (rx_valid_out && exp_rx.size() > 0) begin
        e = exp_rx.pop_front();
        check({4'h0, rx_data_out}, {4'h0, e[4] ? CORRUPT_NIBBLE : e[3:0]});
        check({7'h0, rx_error_out},
              {7'h0, e[4] && speed_100_in && mode_in != MODE_SERIAL});
      end
      if (tx_overflow_out) ovf_count++;
      check({7'h0, carrier_out}, {7'h0, prev_crs});
      check({7'h0, collision_out}, {7'h0, prev_col});
    end
    prev_en = u_phy_mac_link.tx_en;
    prev_crs = u_phy_mac_link.crs;
    // RMII has no collision pin, so the MAC pairs its enable with crs_dv
    prev_col = (mode_in == MODE_RMII) ? (u_phy_mac_link.tx_en && u_phy_mac_link.crs)
                                      : (!full_duplex_in && u_phy_mac_link.col);
  end

  task automatic mac_send(input logic [3:0] d);
    tx_valid_in <= 1'b1;
    tx_data_in  <= d;
    @(negedge clock_in);
    for (int i = 0; i < 500 && tx_ready_out !== 1'b1; i++) @(negedge clock_in);
    @(posedge clock_in);
    exp_tx.push_back(d);
  endtask

  task automatic line_send(input logic [3:0] d, input logic err);
    line_rx_valid_in <= 1'b1;
    line_rx_data_in  <= d;
    line_rx_error_in <= err;
    @(negedge clock_in);
    for (int i = 0; i < 500 && line_rx_ready_out !== 1'b1; i++) @(negedge clock_in);
    @(posedge clock_in);
    exp_rx.push_back({err, d});
  endtask

  task automatic tx_stream(input int n);
    logic [31:0] r;
    for (int i = 0; i < n; i++) begin
      r = draw();
      mac_send(r[3:0]);
    end
    tx_valid_in <= 1'b0;
  endtask

  // Carrier rises with the first offer so serial framing starts aligned
  task automatic rx_stream(input int n, input logic carrier);
    logic [31:0] r;
    if (n > 0) begin
      line_carrier_in <= carrier;
      for (int i = 0; i < n; i++) begin
        r = draw();
        line_send(r[3:0], r[6:4] == 3'h0);
      end
      line_rx_valid_in <= 1'b0;
      line_carrier_in  <= 1'b0;
    end
  endtask

  task automatic run_phase(input logic rm, se, sp, fd, input int ntx, nrx, input logic ovf);
    rst_n_in        <= 1'b0;
    strap_rmii_in   <= rm;
    strap_serial_in <= se;
    speed_100_in    <= sp;
    full_duplex_in  <= fd;
    heartbeat_en_in <= !fd;
    mode_in         <= se ? MODE_SERIAL : (rm ? MODE_RMII : MODE_MII);
    stall = ovf;
    ovf_count = 0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    check({6'h0, mode_out}, {6'h0, mode_in});
    fork
      tx_stream(ntx);
      rx_stream(nrx, !rm);
    join
    if (ovf) begin
      repeat (40) @(posedge clock_in);
      check(8'(ovf_count), 8'(ntx - TX_FIFO_DEPTH));
      while (exp_tx.size() > TX_FIFO_DEPTH) exp_tx.pop_back();
      stall = 1'b0;
    end
    for (int i = 0; i < 4000 && exp_tx.size() + exp_rx.size() > 0; i++) @(posedge clock_in);
    check(8'(exp_tx.size() + exp_rx.size()), 8'h0);
  endtask

  initial begin
    clock_in = 1'b0;
    rst_n_in = 1'b0;
    {strap_rmii_in, strap_serial_in, speed_100_in, full_duplex_in} = 4'h0;
    {heartbeat_en_in, line_carrier_in, line_rx_valid_in, line_rx_error_in} = 4'h0;
    {tx_valid_in, stall, prev_en, line_tx_ready_in} = 4'h0;
    {line_rx_data_in, tx_data_in} = 8'h00;
    mode_in = MODE_MII;
    rnd = 32'he06b99d7;
    run_phase(1'b0, 1'b0, 1'b1, 1'b0, 24, 16, 1'b0);
    run_phase(1'b0, 1'b0, 1'b0, 1'b0, 8, 6, 1'b0);
    run_phase(1'b1, 1'b0, 1'b1, 1'b1, 24, 16, 1'b0);
    run_phase(1'b1, 1'b0, 1'b0, 1'b0, 12, 8, 1'b0);
    run_phase(1'b0, 1'b1, 1'b0, 1'b0, 8, 6, 1'b0);
    run_phase(1'b0, 1'b0, 1'b1, 1'b1, 20, 8, 1'b1);
    finish_test();
  end
endmodule
